// ### design/cwl_top.sv
/*
 Configuration loader and identification block. Holds the configuration
 registers (volatile, loaded from stored words; or nonvolatile) and the two
 identification registers behind a table read / table write port.
 Assumes the table port and the flash read port are on i_clock, flash read
 data valid one cycle after o_flash_rd, and i_sleep / i_disturb asynchronous.
*/
`timescale 1ns/1ps
`default_nettype none
module cwl_top #(
	parameter bit         NONVOL     = 1'b0,
	parameter int         NUM_WORDS  = 3,
	parameter logic [7:0] FAMILY_CODE = 8'h5a,   // Arbitrary value
	parameter logic [7:0] PART_CODE   = 8'h3c,   // Arbitrary value
	parameter logic [3:0] REV_CODE    = 4'h1,    // Arbitrary value
	parameter logic [7:0] NV_ERASED   = 8'hff
) (
	input  wire logic                        i_clock,
	input  wire logic                        i_rst,
	input  wire logic                        i_por,
	input  wire logic                        i_ce,
	input  wire logic [23:0]                 i_tbl_addr,
	input  wire logic                        i_tbl_rd,
	input  wire logic                        i_tbl_wr,
	input  wire logic [15:0]                 i_tbl_wdata,
	output logic      [23:0]                 o_tbl_rdata,
	output logic                             o_tbl_ack,
	output logic      [23:0]                 o_flash_addr,
	output logic                             o_flash_rd,
	input  wire logic [15:0]                 i_flash_data,
	input  wire logic                        i_sleep,
	input  wire logic                        i_disturb,
	output logic      [8*cwl_pkg::CWL_NV_REGS-1:0] o_cfg_bits,
	output logic                             o_cfg_valid,
	output logic                             o_core_rst,
	output logic                             o_config_mismatch_reset
);
	import cwl_pkg::*;

	localparam int NREG = NONVOL ? CWL_NV_REGS : NUM_WORDS;

	cwl_state_t state_r;
	logic [1:0] idx_r;
	logic [7:0] cfg_r     [CWL_NV_REGS];
	logic [7:0] written_r [CWL_NV_REGS];
	logic       sleep_m_r, sleep_s_r, dist_m_r, dist_s_r;
	logic       mm_nxt;
	logic [3:0] wr_dec;
	logic [3:0] rd_dec;
	logic [7:0] wbyte;

	// Hit flag and register index for a table address
	function automatic logic [3:0] cfg_decode(input logic [23:0] a);
		logic [23:0] nv_map [CWL_NV_REGS];
		logic [3:0]  res;
		nv_map = '{CWL_BOOT_ADDR, CWL_GSEG_ADDR, CWL_OSEL_ADDR, CWL_OSC_ADDR,
			CWL_WDT_ADDR, CWL_RST_ADDR, CWL_DBG_ADDR, CWL_DSLP_ADDR};
		res = 4'h0;
		for (int i = 0; i < CWL_NV_REGS; i++) begin
			if (NONVOL ? (a == nv_map[i]) :
				(i < NUM_WORDS && a == CWL_CFG_BASE + 24'(i) * CWL_WORD_STEP)) begin
				res = {1'b1, 3'(i)};
			end
		end
		return res;
	endfunction

	assign wr_dec = cfg_decode(i_tbl_addr);
	assign rd_dec = wr_dec;
	assign wbyte  = i_tbl_wdata[7:0];

	// Pin synchronisers
	always_ff @(posedge i_clock) begin
		if (i_rst) begin
			sleep_m_r <= 1'b0;
			sleep_s_r <= 1'b0;
			dist_m_r  <= 1'b0;
			dist_s_r  <= 1'b0;
		end else if (i_ce) begin
			sleep_m_r <= i_sleep;
			sleep_s_r <= sleep_m_r;
			dist_m_r  <= i_disturb;
			dist_s_r  <= dist_m_r;
		end
	end

	// Mismatch causes
	always_comb begin
		mm_nxt = 1'b0;
		if (NONVOL) begin
			mm_nxt = sleep_s_r && dist_s_r;
		end else if (i_tbl_wr && wr_dec[3] && state_r == CWL_ST_RUN) begin
			// Only bits not yet written count; a change of one resets
			mm_nxt = |((wbyte ^ cfg_r[wr_dec[2:0]]) & ~written_r[wr_dec[2:0]]);
		end
	end

	always_ff @(posedge i_clock) begin
		if (i_rst) begin
			o_config_mismatch_reset <= 1'b0;
		end else if (i_ce) begin
			o_config_mismatch_reset <= mm_nxt;
		end
	end

	// Load sequencer
	always_ff @(posedge i_clock) begin
		if (i_rst) begin
			state_r      <= NONVOL ? CWL_ST_RUN : CWL_ST_REQ;
			idx_r        <= 2'h0;
			o_flash_rd   <= 1'b0;
			o_flash_addr <= CWL_CW1_ADDR;
			o_cfg_valid  <= NONVOL;
			o_core_rst   <= 1'b1;
		end else if (i_ce) begin
			o_flash_rd <= 1'b0;
			o_core_rst <= 1'b0;
			case (state_r)
				CWL_ST_RUN: begin
					if (o_config_mismatch_reset) begin
						o_core_rst <= 1'b1;
						if (!NONVOL) begin
							state_r     <= CWL_ST_REQ;
							idx_r       <= 2'h0;
							o_cfg_valid <= 1'b0;
						end
					end
				end
				CWL_ST_REQ: begin
					o_core_rst   <= 1'b1;
					o_flash_rd   <= 1'b1;
					// Word n sits n steps below the top word
					o_flash_addr <= CWL_CW1_ADDR - 24'(idx_r) * CWL_WORD_STEP;
					state_r      <= CWL_ST_WAIT;
				end
				CWL_ST_WAIT: begin
					o_core_rst <= 1'b1;
					state_r    <= CWL_ST_CAP;
				end
				CWL_ST_CAP: begin
					if (32'(idx_r) == NUM_WORDS - 1) begin
						state_r     <= CWL_ST_RUN;
						o_cfg_valid <= 1'b1;
					end else begin
						o_core_rst <= 1'b1;
						idx_r      <= idx_r + 2'h1;
						state_r    <= CWL_ST_REQ;
					end
				end
				default: begin
					state_r <= CWL_ST_RUN;
				end
			endcase
		end
	end

	// Configuration storage
	always_ff @(posedge i_clock) begin
		if (i_por || (i_rst && !NONVOL)) begin
			// Nonvolatile copy survives the system reset
			for (int i = 0; i < CWL_NV_REGS; i++) begin
				cfg_r[i]     <= NONVOL ? NV_ERASED : CWL_CFG_UNPROG;
				written_r[i] <= 8'h00;
			end
		end else if (i_ce) begin
			if (!NONVOL && state_r == CWL_ST_CAP) begin
				// Upper byte of the stored word carries no bits
				cfg_r[idx_r]     <= i_flash_data[7:0];
				written_r[idx_r] <= 8'h00;
			end else if (i_tbl_wr && wr_dec[3]) begin
				if (NONVOL) begin
					cfg_r[wr_dec[2:0]] <= wbyte;
				end else if (state_r == CWL_ST_RUN && !mm_nxt) begin
					// A matching write marks all eight bits written; cfg_r keeps its loaded byte
					written_r[wr_dec[2:0]] <= 8'hff;
				end
			end
		end
	end

	// Table read port; writes to stored word addresses are not decoded
	always_ff @(posedge i_clock) begin
		if (i_rst) begin
			o_tbl_rdata <= 24'h000000;
			o_tbl_ack   <= 1'b0;
		end else if (i_ce) begin
			o_tbl_ack <= i_tbl_rd || i_tbl_wr;
			if (i_tbl_rd) begin
				if (i_tbl_addr == CWL_ID_ADDR) begin
					o_tbl_rdata <= 24'({FAMILY_CODE, PART_CODE});
				end else if (i_tbl_addr == CWL_REV_ADDR) begin
					o_tbl_rdata <= {20'h00000, REV_CODE[CWL_REV_W-1:0]};
				end else if (rd_dec[3] && 32'(rd_dec[2:0]) < NREG) begin
					o_tbl_rdata <= {16'h0000, cfg_r[rd_dec[2:0]]};
				end else begin
					o_tbl_rdata <= 24'h000000;
				end
			end
		end
	end

	genvar g;
	generate
		for (g = 0; g < CWL_NV_REGS; g++) begin : g_cfg_out
			assign o_cfg_bits[8*g +: 8] = cfg_r[g];
		end
	endgenerate
endmodule // cwl_top
`default_nettype wire

// ### common/cwl_pkg.sv
/*
 Constants, address map and state type of the configuration loader
 and identification block. Assumes a 24-bit table address space with
 word addresses stepping by two.
*/
package cwl_pkg;
	// Stored words, counted downward from the top of program memory
	localparam logic [23:0] CWL_CW1_ADDR   = 24'h002bfe;
	localparam logic [23:0] CWL_WORD_STEP  = 24'h000002;
	localparam int          CWL_WORDS_MIN  = 2;
	localparam int          CWL_WORDS_MAX  = 4;
	// Configuration registers
	localparam int          CWL_NV_REGS    = 8;
	localparam logic [23:0] CWL_CFG_BASE   = 24'hf80000;
	localparam logic [23:0] CWL_BOOT_ADDR  = 24'hf80000;
	localparam logic [23:0] CWL_GSEG_ADDR  = 24'hf80004;
	localparam logic [23:0] CWL_OSEL_ADDR  = 24'hf80006;
	localparam logic [23:0] CWL_OSC_ADDR   = 24'hf80008;
	localparam logic [23:0] CWL_WDT_ADDR   = 24'hf8000a;
	localparam logic [23:0] CWL_RST_ADDR   = 24'hf8000c;
	localparam logic [23:0] CWL_DBG_ADDR   = 24'hf8000e;
	localparam logic [23:0] CWL_DSLP_ADDR  = 24'hf80010;
	localparam logic [7:0]  CWL_CFG_UNPROG = 8'hff;
	// Identification registers
	localparam logic [23:0] CWL_ID_ADDR    = 24'hff0000;
	localparam logic [23:0] CWL_REV_ADDR   = 24'hff0002;
	localparam int          CWL_FAM_LSB    = 8;
	localparam int          CWL_PART_LSB   = 0;
	localparam int          CWL_REV_W      = 4;

	typedef enum logic [1:0] {
		CWL_ST_RUN  = 2'b00,
		CWL_ST_REQ  = 2'b01,
		CWL_ST_WAIT = 2'b10,
		CWL_ST_CAP  = 2'b11
	} cwl_state_t;
endpackage

// ### verification/cwl_chk.sv
/* Port assertions for cwl_top.
 Assumes a bind to cwl_top built as the volatile variant. */
`timescale 1ns/1ps
`default_nettype none
module cwl_chk #(parameter int NUM_WORDS = 3) (
	input wire logic	i_clock,
	input wire logic	i_rst,
	input wire logic	i_por,
	input wire logic	i_ce,
	input wire logic [23:0]	i_tbl_addr,
	input wire logic	i_tbl_rd,
	input wire logic	i_tbl_wr,
	input wire logic [23:0]	o_tbl_rdata,
	input wire logic	o_tbl_ack,
	input wire logic [23:0]	o_flash_addr,
	input wire logic	o_flash_rd,
	input wire logic [63:0]	o_cfg_bits,
	input wire logic	o_cfg_valid,
	input wire logic	o_core_rst,
	input wire logic	o_config_mismatch_reset
);
	default clocking @(posedge i_clock); endclocking
	default disable iff (i_rst || i_por);
	wire logic rq = i_ce && i_tbl_rd;
	wire logic [7:0] cfg0 = o_cfg_bits[7:0];
	property p_ack; i_ce && (i_tbl_rd || i_tbl_wr) |=> o_tbl_ack; endproperty
	a_ack: assert property (p_ack) else $error("no ack");
	property p_id; rq && i_tbl_addr == 24'hff0000 |=> o_tbl_rdata[23:16] == 8'h00; endproperty
	a_id: assert property (p_id) else $error("id top byte");
	property p_rev; rq && i_tbl_addr == 24'hff0002 |=> o_tbl_rdata[23:4] == 20'h0; endproperty
	a_rev: assert property (p_rev) else $error("rev upper bits");
	property p_cfg; rq && i_tbl_addr == 24'hf80000 |=> o_tbl_rdata == {16'h0, $past(cfg0)}; endproperty
	a_cfg: assert property (p_cfg) else $error("cfg read");
	property p_addr; o_flash_rd |-> o_flash_addr <= 24'h002bfe && o_flash_addr >= 24'h002c00 - 2 * NUM_WORDS; endproperty
	a_addr: assert property (p_addr) else $error("flash addr");
	property p_mm; o_config_mismatch_reset |=> o_core_rst && !o_cfg_valid; endproperty
	a_mm: assert property (p_mm) else $error("mismatch reset");
	property p_reload; o_config_mismatch_reset |-> ##[2:30] o_cfg_valid; endproperty
	a_reload: assert property (p_reload) else $error("no reload");
	property p_valid; o_cfg_valid |-> !o_core_rst; endproperty
	a_valid: assert property (p_valid) else $error("core reset");
	property p_hold; o_cfg_valid && $past(o_cfg_valid) |-> $stable(o_cfg_bits); endproperty
	a_hold: assert property (p_hold) else $error("cfg changed");
endmodule // cwl_chk
bind cwl_top cwl_chk #(.NUM_WORDS(NUM_WORDS)) u_chk (.i_clock, .i_rst, .i_por, .i_ce, .i_tbl_addr, .i_tbl_rd,
	.i_tbl_wr, .o_tbl_rdata, .o_tbl_ack, .o_flash_addr, .o_flash_rd, .o_cfg_bits, .o_cfg_valid,
	.o_core_rst, .o_config_mismatch_reset);
`default_nettype wire

// ### verification/tb_top.sv
/* Bench for cwl_top, volatile variant.
 Assumes the bench plays table master and stored words. */
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	import cwl_pkg::*;
	localparam int NCW = 3;
	localparam logic [7:0] FAM = 8'ha7, PRT = 8'h19; // Arbitrary values
	localparam logic [3:0] REV = 4'h6; // Arbitrary value
	logic i_clock = 1'b0, i_rst = 1'b1, i_tbl_rd = 1'b0, i_tbl_wr = 1'b0, prd = 1'b0, mm;
	logic [23:0] i_tbl_addr = 24'h0, o_tbl_rdata, o_flash_addr;
	logic [15:0] i_tbl_wdata = 16'h0, i_flash_data = 16'h0;
	logic o_tbl_ack, o_flash_rd, o_cfg_valid, o_core_rst, o_config_mismatch_reset;
	logic [63:0] o_cfg_bits;
	logic [15:0] fw [4] = '{16'hff12, 16'h7e34, 16'hff56, 16'hffff};
	int mismatches = 0, comparisons = 0;
	always #4 i_clock = ~i_clock;
	// Stored words; changing pattern outside reads
	always @(negedge i_clock) begin
		i_flash_data <= (o_flash_rd || prd) ? fw[2'((24'h002bfe - o_flash_addr) >> 1)] : ~i_flash_data;
		prd <= o_flash_rd;
	end
	cwl_top #(.NUM_WORDS(NCW), .FAMILY_CODE(FAM), .PART_CODE(PRT), .REV_CODE(REV)) i_dut (
		.i_clock, .i_rst, .i_por(1'b0), .i_ce(1'b1), .i_tbl_addr, .i_tbl_rd, .i_tbl_wr, .i_tbl_wdata,
		.o_tbl_rdata, .o_tbl_ack, .o_flash_addr, .o_flash_rd, .i_flash_data, .i_sleep(1'b0),
		.i_disturb(1'b0), .o_cfg_bits, .o_cfg_valid, .o_core_rst, .o_config_mismatch_reset);
	task automatic chk(string nm, logic [63:0] exp, logic [63:0] got);
		comparisons++;
		if (got !== exp) begin
			mismatches++;
			$display("wrong value %s expected %h seen %h", nm, exp, got);
		end
	endtask
	task automatic tx(logic wr, logic [23:0] a, logic [7:0] d, logic [23:0] exp);
		@(negedge i_clock);
		{i_tbl_wr, i_tbl_rd, i_tbl_addr, i_tbl_wdata} = {wr, !wr, a, 8'hff, d};
		@(negedge i_clock);
		{i_tbl_wr, i_tbl_rd} = 2'b00;
		mm = o_config_mismatch_reset;
		chk("ack", 1'b1, o_tbl_ack);
		if (!wr) chk("rdata", exp, o_tbl_rdata);
	endtask
	task automatic wait_load(int en);
		int n;
		n = 0;
		while (o_cfg_valid !== 1'b1 && n < 60) begin
			@(negedge i_clock);
			n++;
		end
		if (en > 0) chk("load cycles", en, n);
		chk("cfg", {40'hff_ffff_ffff, fw[2][7:0], fw[1][7:0], fw[0][7:0]}, o_cfg_bits);
		chk("core reset", 1'b0, o_core_rst);
	endtask
	task automatic t_id;
		tx(0, CWL_ID_ADDR, 0, {8'h00, FAM, PRT});
		tx(0, CWL_REV_ADDR, 0, {20'h0, REV});
		tx(1, CWL_ID_ADDR, 8'h00, 0);
		tx(0, CWL_ID_ADDR, 0, {8'h00, FAM, PRT});
		$display("t_id done");
	endtask
	task automatic t_once;
		tx(0, CWL_BOOT_ADDR, 0, {16'h0, fw[0][7:0]});
		tx(1, CWL_BOOT_ADDR, fw[0][7:0], 0);
		chk("mismatch", 1'b0, mm);
		tx(1, CWL_BOOT_ADDR, 8'h00, 0);
		chk("mismatch", 1'b0, mm);
		tx(0, CWL_BOOT_ADDR, 0, {16'h0, fw[0][7:0]});
		$display("t_once done");
	endtask
	task automatic t_reload;
		tx(1, 24'h002bfa, 8'h9c, 0);
		chk("mismatch", 1'b0, mm);
		fw[2] = 16'hff9c;
		tx(0, 24'hf80004, 0, 24'h000056);
		tx(1, 24'hf80002, 8'h00, 0);
		chk("mismatch", 1'b1, mm);
		@(negedge i_clock);
		chk("core reset", 1'b1, o_core_rst);
		wait_load(0);
		$display("t_reload done");
	endtask
	// Mid-run system reset picks up rewritten stored words
	task automatic t_reset;
		fw[0] = 16'hff77;
		@(negedge i_clock);
		i_rst = 1'b1;
		repeat (2) @(negedge i_clock);
		i_rst = 1'b0;
		wait_load(3 * NCW);
		tx(0, CWL_BOOT_ADDR, 0, 24'h000077);
		$display("t_reset done");
	endtask
	task automatic report_and_stop;
		$display("comparisons %0d mismatches %0d", comparisons, mismatches);
		if (mismatches == 0 && comparisons > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	initial begin
		repeat (8) @(negedge i_clock);
		i_rst = 1'b0;
		wait_load(3 * NCW);
		t_id();
		t_once();
		t_reload();
		t_reset();
		report_and_stop();
	end
	// Generous bound on the whole run
	initial begin
		#20000;
		mismatches++;
		report_and_stop();
	end
endmodule // tb_top
`default_nettype wire
